/* File: fline_unimpl_fp_trap_tb.sv */
// Self-checking bench for the F-line trap sequencer
`timescale 1ns/1ps
`include "fut_defines.svh"
module fline_unimpl_fp_trap_tb import fut_pkg::*;;
    logic        clk, sys_rst, op_valid, fp_busy, fp_exc_pend, exc_taken, reads_busy;
    logic        access_err, bkpt_cyc, transfer_ack_n, transfer_error_ack_n;
    logic [15:0] op_word, ext_word, status_in, status_out, exp_st, r_st;
    logic [31:0] next_pc, eff_addr, vec_base;
    logic        opnd_done, conv_done, stack_done, vec_fetched, prefetch_full;
    logic        op_accept, impl_go, fp_sync_req, opnd_fetch, fp_conv_req, restart, status_wr;
    logic        vec_fetch, prefetch_req, handler_go, bkpt_illegal, unimp_state;
    logic [5:0]  save_words, r_save;
    logic [3:0]  lat;       // Partner answer latency
    fut_exc_s    exc_req, r_exc;
    fut_frame_s  frame, r_frm;
    // Event records, cleared before each instruction
    logic        r_take, r_impl, r_rst, r_hgo, r_pf, r_hgo_early;
    logic        r_fetch, r_fetch_early, r_conv, r_sync, r_unimp;
    int          num_errors, num_checks, cyc;

    fut_trap dut (.CLK(clk), .SYS_RST(sys_rst), .OP_VALID(op_valid), .OP_WORD(op_word),
        .EXT_WORD(ext_word), .NEXT_PC(next_pc), .EFF_ADDR(eff_addr), .VEC_BASE(vec_base),
        .STATUS_IN(status_in), .FP_BUSY(fp_busy), .FP_EXC_PEND(fp_exc_pend),
        .EXC_TAKEN(exc_taken), .READS_BUSY(reads_busy), .OPND_DONE(opnd_done),
        .ACCESS_ERR(access_err), .FP_CONV_DONE(conv_done), .STACK_DONE(stack_done),
        .VEC_FETCHED(vec_fetched), .PREFETCH_FULL(prefetch_full), .BKPT_ACK_CYC(bkpt_cyc),
        .transfer_ack_n(transfer_ack_n), .transfer_error_ack_n(transfer_error_ack_n),
        .OP_ACCEPT(op_accept),
        .IMPL_GO(impl_go), .FP_SYNC_REQ(fp_sync_req), .OPND_FETCH(opnd_fetch),
        .FP_CONV_REQ(fp_conv_req), .RESTART(restart), .STATUS_OUT(status_out),
        .STATUS_WR(status_wr), .EXC_REQ(exc_req), .FRAME(frame), .VEC_FETCH(vec_fetch),
        .PREFETCH_REQ(prefetch_req), .HANDLER_GO(handler_go), .BKPT_ILLEGAL(bkpt_illegal),
        .SAVE_WORDS(save_words), .UNIMP_STATE(unimp_state));
    // Partner answers for each step level
    fut_resp u_opnd (.clk(clk), .rst(sys_rst), .req(opnd_fetch), .lat(lat), .done(opnd_done));
    fut_resp u_conv (.clk(clk), .rst(sys_rst), .req(fp_conv_req), .lat(lat), .done(conv_done));
    fut_resp u_stk (.clk(clk), .rst(sys_rst), .req(exc_req.take), .lat(lat), .done(stack_done));
    fut_resp u_vec (.clk(clk), .rst(sys_rst), .req(vec_fetch), .lat(lat), .done(vec_fetched));
    fut_resp u_pf (.clk(clk), .rst(sys_rst), .req(prefetch_req), .lat(lat), .done(prefetch_full));

    // 40 MHz clock
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // Hang guard: a stalled run counts as a mismatch
    always @(posedge clk) begin
        cyc++;
        if (cyc > 6000) begin
            num_errors++;
            end_sim();
        end
    end

    // Event recorder
    always @(posedge clk) begin
        if (exc_req.take) begin
            r_take = 1'b1;
            r_exc  = exc_req;
            r_frm  = frame;
        end
        if (status_wr) r_st = status_out;
        if (unimp_state) begin
            r_unimp = 1'b1;
            r_save  = save_words;
        end
        if (handler_go && !r_pf) r_hgo_early = 1'b1;
        if (opnd_fetch && reads_busy) r_fetch_early = 1'b1;
        r_impl |= impl_go;
        r_rst |= restart;
        r_hgo |= handler_go;
        r_pf |= prefetch_full;
        r_fetch |= opnd_fetch;
        r_conv |= fp_conv_req;
        r_sync |= fp_sync_req;
    end

    task automatic step();
        @(posedge clk);
        #2;
    endtask : step

    task automatic chk(input logic [95:0] got, input logic [95:0] exp);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // Present one instruction for one sampling edge
    task automatic send(input logic [15:0] op, input logic [15:0] ext);
        {r_take, r_impl, r_rst, r_hgo, r_pf, r_hgo_early} = '0;
        {r_fetch, r_fetch_early, r_conv, r_sync, r_unimp} = '0;
        r_st     = '0;
        op_word  = op;
        ext_word = ext;
        op_valid = 1'b1;
        step();
        op_valid = 1'b0;
    endtask : send

    // Bounded wait for the end of a sequence
    task automatic wait_end(input int n);
        for (int i = 0; i < n; i++) begin
            if (r_hgo || r_rst || r_impl) break;
            step();
        end
    endtask : wait_end

    task automatic t_impl();
        send(16'hf200, 16'h0023);
        chk({op_accept, impl_go}, 2'b11);
        wait_end(10);
        repeat (8) step();
        chk({r_impl, r_take}, 2'b10);
        send(16'hf4f8, 16'h0000);
        wait_end(10);
        repeat (8) step();
        chk({r_impl, r_take}, 2'b10);
    endtask : t_impl

    task automatic t_ill();
        send(16'hffff, 16'h0000);
        wait_end(60);
        chk({r_exc.format, r_exc.words, r_exc.vector},
            {`FUT_FMT_ZERO, `FUT_FRAME0_WORDS, `FUT_VEC_FLINE});
        chk(r_exc.vec_addr, vec_base + 32'h0000_002c);
        chk(r_st, exp_st);
    endtask : t_ill

    // Busy floating-point unit holds the trap back
    task automatic t_unimp();
        fp_busy = 1'b1;
        send(16'hf200, 16'h000e);
        repeat (6) step();
        chk({fp_sync_req, r_take, r_conv}, 3'b100);
        fp_busy = 1'b0;
        lat     = 4'h6;
        wait_end(120);
        lat     = 4'h1;
        chk({r_exc.format, r_exc.words, r_exc.vector},
            {`FUT_FMT_TWO, `FUT_FRAME2_WORDS, `FUT_VEC_FLINE});
        chk({r_frm.vec_off[11:0], r_frm.pc, r_frm.psw, r_frm.ea},
            {12'h02c, next_pc, status_in, eff_addr});
        chk(r_st, exp_st);
        chk({r_hgo, r_hgo_early, r_fetch}, 3'b100);
        chk({r_unimp, r_save}, {1'b1, `FUT_SAVE_WORDS});
    endtask : t_unimp

    // Memory source waits for earlier reads, then converts
    task automatic t_mem();
        reads_busy = 1'b1;
        send(16'hf210, 16'h400e);
        repeat (5) step();
        chk({opnd_fetch, r_fetch}, 2'b00);
        reads_busy = 1'b0;
        wait_end(60);
        chk({r_fetch, r_fetch_early, r_conv, r_take}, 4'b1011);
    endtask : t_mem

    // Access error restarts, the retry then completes
    task automatic t_aerr();
        access_err = 1'b1;
        send(16'hf210, 16'h400e);
        wait_end(20);
        access_err = 1'b0;
        chk({r_rst, r_take}, 2'b10);
        send(16'hf210, 16'h400e);
        wait_end(60);
        chk({r_hgo, r_take}, 2'b11);
        // Error inside the operand fetch itself, partner held slow
        lat = 4'h8;
        send(16'hf210, 16'h400e);
        for (int i = 0; i < 20 && !opnd_fetch; i++) step();
        access_err = 1'b1;
        wait_end(20);
        access_err = 1'b0;
        lat        = 4'h1;
        chk({r_rst, r_fetch, r_take}, 3'b110);
    endtask : t_aerr

    // Pending exception is taken first, trap abandoned
    task automatic t_pend();
        fp_exc_pend = 1'b1;
        send(16'hf200, 16'h000e);
        repeat (3) step();
        exc_taken   = 1'b1;
        fp_exc_pend = 1'b0;
        step();
        exc_taken   = 1'b0;
        repeat (10) step();
        chk({r_sync, r_take, r_conv}, 3'b100);
    endtask : t_pend

    // Breakpoint cycle ended by each acknowledge in turn
    task automatic t_bkpt();
        for (int i = 0; i < 2; i++) begin
            bkpt_cyc = 1'b1;
            transfer_ack_n       = (i != 0);
            transfer_error_ack_n = (i == 0);
            repeat (6) step();
            chk(bkpt_illegal, 1'b1);
            transfer_ack_n       = 1'b1;
            transfer_error_ack_n = 1'b1;
            repeat (6) step();
            chk(bkpt_illegal, 1'b0);
            bkpt_cyc = 1'b0;
        end
    endtask : t_bkpt

    task automatic end_sim();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : end_sim

    // Main sequence
    initial begin
        {op_valid, fp_busy, fp_exc_pend, exc_taken, reads_busy, access_err, bkpt_cyc} = '0;
        {transfer_ack_n, transfer_error_ack_n} = 2'b11;
        {op_word, ext_word} = '0;
        lat       = 4'h1;
        status_in = 16'hc715;
        next_pc   = 32'h0000_1004;
        eff_addr  = 32'h0000_2000;
        vec_base  = 32'h0001_0000;
        exp_st    = (status_in | 16'h1 << `FUT_PSW_SUPER_BIT)
                  & ~(16'h1 << `FUT_PSW_TRC_HI_BIT | 16'h1 << `FUT_PSW_TRC_LO_BIT);
        sys_rst   = 1'b1;
        repeat (16) @(posedge clk);
        #2;
        chk({op_accept, exc_req.take, status_wr, handler_go, bkpt_illegal}, 5'h00);
        sys_rst = 1'b0;
        step();
        t_impl();
        t_ill();
        t_unimp();
        t_mem();
        t_aerr();
        t_pend();
        t_bkpt();
        end_sim();
    end
endmodule : fline_unimpl_fp_trap_tb

/* File: fut_addr.sv */
// Vector table address former
`timescale 1ns/1ps
module fut_addr import fut_pkg::*; (
    input  wire logic [31:0] vbr,
    input  wire logic [7:0]  vector,
    output logic [31:0]      vec_addr,
    output logic [15:0]      vec_off
);
    `include "fut_defines.svh"
    // Offset is vector times four; 11 lands at 2c
    assign vec_off  = {6'h00, vector, 2'h0};
    assign vec_addr = vbr + {22'h000000, vector, 2'h0};
endmodule : fut_addr

/* File: fut_decode.sv */
// F-line opcode classifier: implemented, unimplemented floating-point, illegal
`timescale 1ns/1ps
module fut_decode import fut_pkg::*; (
    input  wire logic [15:0] op_word,
    input  wire logic [15:0] ext_word,
    output fut_cls_e         cls,
    output logic             needs_mem
);
    `include "fut_defines.svh"

    // F-line group detect
    wire        is_fline  = (op_word[15:12] == 4'hf);
    wire        is_fpgen  = (op_word[11:9] == `FUT_FP_CPID) && (op_word[8:6] == 3'h0);
    wire        rm_bit    = ext_word[14];
    wire [6:0]  ext_op    = ext_word[6:0];
    wire        opclass_ok = (ext_word[15:13] == 3'h0) || (ext_word[15:13] == 3'h2);
    wire        movecr    = (ext_word[15:10] == 6'h17); // constant ROM load
    // Cache maintenance lives in coprocessor id 2 space
    wire        is_cache  = (op_word[11:8] == 4'h4);
    // Save/restore and control moves are implemented
    wire        is_ctl    = (op_word[11:9] == `FUT_FP_CPID) && (op_word[8:6] != 3'h0);

    // Transcendental and friends, indexed by extension opmode
    function automatic logic unimp_op(input logic [6:0] o);
        case (o)
            7'h01, 7'h02, 7'h03, 7'h06, 7'h08, 7'h09, 7'h0a, 7'h0c,
            7'h0d, 7'h0e, 7'h0f, 7'h10, 7'h11, 7'h12, 7'h14, 7'h15,
            7'h16, 7'h19, 7'h1c, 7'h1d, 7'h1e, 7'h1f, 7'h21, 7'h25,
            7'h26, 7'h30, 7'h31, 7'h32, 7'h33, 7'h34, 7'h35, 7'h36,
            7'h37: unimp_op = 1'b1;
            default: unimp_op = 1'b0;
        endcase
    endfunction : unimp_op

    // Arithmetic the unit does in hardware
    function automatic logic impl_op(input logic [6:0] o);
        case (o)
            7'h00, 7'h04, 7'h18, 7'h1a, 7'h20, 7'h22, 7'h23, 7'h24,
            7'h27, 7'h28, 7'h38, 7'h3a, 7'h40, 7'h41, 7'h44, 7'h45,
            7'h58, 7'h5a, 7'h5c, 7'h5e, 7'h60, 7'h62, 7'h63, 7'h64,
            7'h66, 7'h67, 7'h68, 7'h6c: impl_op = 1'b1;
            default: impl_op = 1'b0;
        endcase
    endfunction : impl_op

    wire gen_unimp = is_fpgen && ((opclass_ok && unimp_op(ext_op)) || movecr);
    wire gen_impl  = (is_fpgen && opclass_ok && impl_op(ext_op) && !movecr)
                   || (is_fpgen && ext_word[15:13] == 3'h3)
                   || is_ctl || is_cache;

    // Priority: implemented, then unimplemented, else illegal
    assign cls = !is_fline ? FUT_CLS_NONE :
                 gen_impl  ? FUT_CLS_IMPL :
                 gen_unimp ? FUT_CLS_UNIMP : FUT_CLS_ILL;
    assign needs_mem = rm_bit && !movecr && (op_word[5:3] != 3'h0);
endmodule : fut_decode

/* File: fut_defines.svh */
// Constants for the F-line classifier and unimplemented floating-point trap sequencer
`ifndef FUT_DEFINES_SVH
`define FUT_DEFINES_SVH
`define FUT_VEC_FLINE      8'h0b
`define FUT_VEC_SHIFT      2
`define FUT_FMT_ZERO       4'h0
`define FUT_FMT_TWO        4'h2
`define FUT_FRAME0_WORDS   4'h4
`define FUT_FRAME2_WORDS   4'h6
`define FUT_SAVE_WORDS     6'h1a
`define FUT_PSW_SUPER_BIT  13
`define FUT_PSW_TRC_HI_BIT 15
`define FUT_PSW_TRC_LO_BIT 14
`define FUT_FP_CPID        3'h1
`endif

/* File: fut_pkg.sv */
// Types for the F-line classifier and trap sequencer
package fut_pkg;
    typedef enum logic [1:0] {
        FUT_CLS_NONE  = 2'h0,
        FUT_CLS_IMPL  = 2'h1,
        FUT_CLS_UNIMP = 2'h2,
        FUT_CLS_ILL   = 2'h3
    } fut_cls_e;

    typedef enum logic [3:0] {
        FUT_ST_IDLE   = 4'h0,
        FUT_ST_DRAIN  = 4'h1,
        FUT_ST_RDWAIT = 4'h2,
        FUT_ST_FETCH  = 4'h3,
        FUT_ST_CONV   = 4'h4,
        FUT_ST_SRSAVE = 4'h5,
        FUT_ST_PUSH   = 4'h6,
        FUT_ST_VEC    = 4'h7,
        FUT_ST_REFILL = 4'h8,
        FUT_ST_ILL    = 4'h9
    } fut_st_e;

    // Exception request presented to the core's stacking logic
    typedef struct packed {
        logic        take;
        logic [3:0]  format;
        logic [3:0]  words;
        logic [7:0]  vector;
        logic [31:0] vec_addr;
    } fut_exc_s;

    // Frame contents of a format-two push
    typedef struct packed {
        logic [15:0] vec_off;
        logic [31:0] pc;
        logic [15:0] psw;
        logic [31:0] ea;
    } fut_frame_s;
endpackage : fut_pkg

/* File: fut_resp.sv */
// Handshake responder standing in for the core and floating-point unit
`timescale 1ns/1ps
module fut_resp import fut_pkg::*; (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       req,
    input  wire logic [3:0] lat,
    output logic            done
);
    logic [3:0] cnt_q;  // Cycles spent on this request
    logic       srv_q;  // Answered, waiting for the request to drop
    // One answer per request; a held level must not earn a second pulse
    always_ff @(posedge clk) begin
        if (rst || !req) begin
            cnt_q <= 4'h0;
            srv_q <= 1'b0;
            done  <= 1'b0;
        end else begin
            done <= 1'b0;
            if (!srv_q) begin
                cnt_q <= cnt_q + 4'h1;
                // Request answered: operand, conversion, stacking, vector or refill done
                if (cnt_q >= lat) begin
                    done  <= 1'b1;
                    srv_q <= 1'b1;
                end
            end
        end
    end
endmodule : fut_resp

/* File: fut_trap.sv */
// Unimplemented floating-point trap sequencer with F-line classification
`timescale 1ns/1ps
module fut_trap import fut_pkg::*; (
    input  wire logic        CLK,
    input  wire logic        SYS_RST,
    input  wire logic        OP_VALID,
    input  wire logic [15:0] OP_WORD,
    input  wire logic [15:0] EXT_WORD,
    input  wire logic [31:0] NEXT_PC,
    input  wire logic [31:0] EFF_ADDR,
    input  wire logic [31:0] VEC_BASE,
    input  wire logic [15:0] STATUS_IN,
    input  wire logic        FP_BUSY,
    input  wire logic        FP_EXC_PEND,
    input  wire logic        EXC_TAKEN,
    input  wire logic        READS_BUSY,
    input  wire logic        OPND_DONE,
    input  wire logic        ACCESS_ERR,
    input  wire logic        FP_CONV_DONE,
    input  wire logic        STACK_DONE,
    input  wire logic        VEC_FETCHED,
    input  wire logic        PREFETCH_FULL,
    input  wire logic        BKPT_ACK_CYC,
    input  wire logic        transfer_ack_n,
    input  wire logic        transfer_error_ack_n,
    output logic             OP_ACCEPT,
    output logic             IMPL_GO,
    output logic             FP_SYNC_REQ,
    output logic             OPND_FETCH,
    output logic             FP_CONV_REQ,
    output logic             RESTART,
    output logic [15:0]      STATUS_OUT,
    output logic             STATUS_WR,
    output fut_exc_s         EXC_REQ,
    output fut_frame_s       FRAME,
    output logic             VEC_FETCH,
    output logic             PREFETCH_REQ,
    output logic             HANDLER_GO,
    output logic             BKPT_ILLEGAL,
    output logic [5:0]       SAVE_WORDS,
    output logic             UNIMP_STATE
);
    `include "fut_defines.svh"

    fut_st_e    st_q, st_d;          // Sequencer state
    fut_cls_e   cls;                 // Decoded class
    logic       needs_mem;           // Memory source required
    logic       mem_q;               // Latched memory need
    logic [15:0] psw_copy_q;         // Internal status copy
    logic [31:0] pc_q, ea_q;         // Captured next PC and address
    logic [7:0]  vec_q;              // Vector in progress
    logic [31:0] vec_addr;           // Table address
    logic [15:0] vec_off;            // Frame offset field
    logic        bk_ack_n_1, bk_ack_n_2, bk_ack_n_3; // Ack synchroniser
    logic        bk_te_n_1, bk_te_n_2, bk_te_n_3;   // Error ack synchroniser
    logic        bk_cyc_1, bk_cyc_2, bk_cyc_3;      // Cycle synchroniser

    fut_decode u_dec (
        .op_word   (OP_WORD),
        .ext_word  (EXT_WORD),
        .cls       (cls),
        .needs_mem (needs_mem)
    );

    fut_addr u_addr (
        .vbr      (VEC_BASE),
        .vector   (vec_q),
        .vec_addr (vec_addr),
        .vec_off  (vec_off)
    );

    // Named decode of the current state
    wire idle    = (st_q == FUT_ST_IDLE);
    wire start_u = idle && OP_VALID && (cls == FUT_CLS_UNIMP);
    wire start_i = idle && OP_VALID && (cls == FUT_CLS_ILL);
    // Status with supervisor set and both trace bits cleared
    wire [15:0] psw_super = (psw_copy_q | (16'h0001 << `FUT_PSW_SUPER_BIT))
                          & ~(16'h0001 << `FUT_PSW_TRC_HI_BIT)
                          & ~(16'h0001 << `FUT_PSW_TRC_LO_BIT);
    // Stable, agreeing synchroniser stages mark a terminated cycle
    wire bk_term = bk_cyc_3 && bk_cyc_2
                 && ((!bk_ack_n_2 && !bk_ack_n_3) || (!bk_te_n_2 && !bk_te_n_3));

    // Next-state logic
    always_comb begin
        st_d = st_q;
        case (st_q)
            FUT_ST_IDLE: begin
                if (start_u) st_d = FUT_ST_DRAIN;
                else if (start_i) st_d = FUT_ST_ILL;
            end
            // Earlier FP work and pending exceptions go first
            FUT_ST_DRAIN: begin
                if (EXC_TAKEN) st_d = FUT_ST_IDLE;
                else if (!FP_BUSY && !FP_EXC_PEND) st_d = FUT_ST_RDWAIT;
            end
            // Earlier reads must finish before our read starts
            FUT_ST_RDWAIT: begin
                if (ACCESS_ERR) st_d = FUT_ST_IDLE;
                else if (!READS_BUSY) st_d = mem_q ? FUT_ST_FETCH : FUT_ST_CONV;
            end
            FUT_ST_FETCH: begin
                if (ACCESS_ERR) st_d = FUT_ST_IDLE;
                else if (OPND_DONE) st_d = FUT_ST_CONV;
            end
            FUT_ST_CONV:   if (FP_CONV_DONE) st_d = FUT_ST_SRSAVE;
            FUT_ST_SRSAVE: st_d = FUT_ST_PUSH;
            FUT_ST_PUSH:   if (STACK_DONE) st_d = FUT_ST_VEC;
            FUT_ST_VEC:    if (VEC_FETCHED) st_d = FUT_ST_REFILL;
            FUT_ST_REFILL: if (PREFETCH_FULL) st_d = FUT_ST_IDLE;
            // Illegal path reuses stacking and vector steps
            FUT_ST_ILL:    st_d = FUT_ST_SRSAVE;
            default:       st_d = FUT_ST_IDLE;
        endcase
    end

    // State register
    always_ff @(posedge CLK) begin
        if (SYS_RST) st_q <= FUT_ST_IDLE;
        else         st_q <= st_d;
    end

    // Capture instruction context at acceptance
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            mem_q <= 1'b0;
            pc_q  <= 32'h00000000;
            ea_q  <= 32'h00000000;
            vec_q <= 8'h00;
        end else if (start_u || start_i) begin
            mem_q <= needs_mem;
            pc_q  <= NEXT_PC;   // Points past the trapping instruction
            ea_q  <= EFF_ADDR;
            vec_q <= `FUT_VEC_FLINE;
        end
    end

    // Status copy is taken first, before mode changes
    always_ff @(posedge CLK) begin
        if (SYS_RST) psw_copy_q <= 16'h0000;
        else if ((st_q == FUT_ST_CONV && FP_CONV_DONE) || st_q == FUT_ST_ILL)
            psw_copy_q <= STATUS_IN;
    end

    // Three-stage synchronisers on breakpoint pins
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            {bk_ack_n_1, bk_ack_n_2, bk_ack_n_3} <= 3'h7;
            {bk_te_n_1, bk_te_n_2, bk_te_n_3} <= 3'h7;
            {bk_cyc_1, bk_cyc_2, bk_cyc_3}    <= 3'h0;
        end else begin
            {bk_ack_n_3, bk_ack_n_2, bk_ack_n_1} <= {bk_ack_n_2, bk_ack_n_1, transfer_ack_n};
            {bk_te_n_3, bk_te_n_2, bk_te_n_1} <= {bk_te_n_2, bk_te_n_1, transfer_error_ack_n};
            {bk_cyc_3, bk_cyc_2, bk_cyc_1}    <= {bk_cyc_2, bk_cyc_1, BKPT_ACK_CYC};
        end
    end

    // Registered outputs; every top output comes from a flop
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            OP_ACCEPT    <= 1'b0;
            IMPL_GO      <= 1'b0;
            FP_SYNC_REQ  <= 1'b0;
            OPND_FETCH   <= 1'b0;
            FP_CONV_REQ  <= 1'b0;
            RESTART      <= 1'b0;
            STATUS_OUT   <= 16'h0000;
            STATUS_WR    <= 1'b0;
            EXC_REQ      <= '0;
            FRAME        <= '0;
            VEC_FETCH    <= 1'b0;
            PREFETCH_REQ <= 1'b0;
            HANDLER_GO   <= 1'b0;
            BKPT_ILLEGAL <= 1'b0;
            SAVE_WORDS   <= 6'h00;
            UNIMP_STATE  <= 1'b0;
        end else begin
            OP_ACCEPT    <= idle && OP_VALID;
            IMPL_GO      <= idle && OP_VALID && (cls == FUT_CLS_IMPL);
            FP_SYNC_REQ  <= (st_d == FUT_ST_DRAIN);
            OPND_FETCH   <= (st_d == FUT_ST_FETCH);
            // Only the source is converted; the destination keeps its own format
            FP_CONV_REQ  <= (st_d == FUT_ST_CONV);
            RESTART      <= ACCESS_ERR
                         && (st_q == FUT_ST_RDWAIT || st_q == FUT_ST_FETCH);
            STATUS_WR    <= (st_q == FUT_ST_SRSAVE);
            if (st_q == FUT_ST_SRSAVE) STATUS_OUT <= psw_super;
            // Frame request: format two for unimplemented, zero for illegal
            EXC_REQ.take     <= (st_q == FUT_ST_SRSAVE) || (st_q == FUT_ST_PUSH && !STACK_DONE);
            if (st_q == FUT_ST_SRSAVE) begin
                EXC_REQ.format   <= UNIMP_STATE ? `FUT_FMT_TWO : `FUT_FMT_ZERO;
                EXC_REQ.words    <= UNIMP_STATE ? `FUT_FRAME2_WORDS
                                                : `FUT_FRAME0_WORDS;
                EXC_REQ.vector   <= vec_q;
                EXC_REQ.vec_addr <= vec_addr;
                FRAME.vec_off    <= vec_off;
                FRAME.pc         <= pc_q;
                FRAME.psw        <= psw_copy_q;
                FRAME.ea         <= UNIMP_STATE ? ea_q : 32'h00000000;
            end
            VEC_FETCH    <= (st_d == FUT_ST_VEC);
            PREFETCH_REQ <= (st_d == FUT_ST_REFILL);
            HANDLER_GO   <= (st_q == FUT_ST_REFILL) && PREFETCH_FULL;
            BKPT_ILLEGAL <= bk_term;
            // Unimplemented state stays armed for the handler's state save
            if (start_u) UNIMP_STATE <= 1'b1;
            else if (start_i || RESTART || (st_q == FUT_ST_DRAIN && EXC_TAKEN))
                UNIMP_STATE <= 1'b0;
            SAVE_WORDS   <= UNIMP_STATE ? `FUT_SAVE_WORDS : 6'h00;
        end
    end
    // Operand storage for the state save lives in the FP unit, not here

    // Checks
    property p_drain_first;
        @(posedge CLK) disable iff (SYS_RST)
        (st_q == FUT_ST_DRAIN && (FP_BUSY || FP_EXC_PEND)) |=> (st_q != FUT_ST_RDWAIT);
    endproperty
    a_drain_first: assert property (p_drain_first) else $error("left drain early");

    property p_fetch_after_reads;
        @(posedge CLK) disable iff (SYS_RST)
        (st_q == FUT_ST_RDWAIT && READS_BUSY) |=> (st_q != FUT_ST_FETCH);
    endproperty
    a_fetch_after_reads: assert property (p_fetch_after_reads) else $error("fetch too soon");

    property p_restart;
        @(posedge CLK) disable iff (SYS_RST)
        (ACCESS_ERR && (st_q == FUT_ST_RDWAIT || st_q == FUT_ST_FETCH))
            |=> (RESTART && st_q == FUT_ST_IDLE);
    endproperty
    a_restart: assert property (p_restart) else $error("no restart on error");

    property p_psw_super;
        @(posedge CLK) disable iff (SYS_RST)
        STATUS_WR |-> (STATUS_OUT[`FUT_PSW_SUPER_BIT] && !STATUS_OUT[`FUT_PSW_TRC_HI_BIT]
                       && !STATUS_OUT[`FUT_PSW_TRC_LO_BIT]);
    endproperty
    a_psw_super: assert property (p_psw_super) else $error("bad trap status");

    property p_vector;
        @(posedge CLK) disable iff (SYS_RST)
        STATUS_WR |-> (EXC_REQ.vector == 8'h0b && EXC_REQ.vec_addr == VEC_BASE + 32'h2c);
    endproperty
    a_vector: assert property (p_vector) else $error("wrong vector");

    property p_format;
        @(posedge CLK) disable iff (SYS_RST)
        STATUS_WR |-> (EXC_REQ.format == (UNIMP_STATE ? 4'h2 : 4'h0));
    endproperty
    a_format: assert property (p_format) else $error("wrong frame format");

    sequence s_refill_done;
        (st_q == FUT_ST_REFILL && PREFETCH_FULL) ##1 HANDLER_GO;
    endsequence
    property p_handler;
        @(posedge CLK) disable iff (SYS_RST)
        $rose(HANDLER_GO) |-> $past(st_q == FUT_ST_REFILL && PREFETCH_FULL);
    endproperty
    a_handler: assert property (p_handler) else $error("handler before refill");

    property p_impl_no_trap;
        @(posedge CLK) disable iff (SYS_RST)
        (idle && OP_VALID && cls == FUT_CLS_IMPL) |=> (st_q == FUT_ST_IDLE && IMPL_GO);
    endproperty
    a_impl_no_trap: assert property (p_impl_no_trap) else $error("implemented op trapped");

    property p_bkpt;
        @(posedge CLK) disable iff (SYS_RST)
        bk_term |=> BKPT_ILLEGAL;
    endproperty
    a_bkpt: assert property (p_bkpt) else $error("breakpoint not reported");

    // Full pipeline releases the handler on the very next cycle
    property p_handler_next;
        @(posedge CLK) disable iff (SYS_RST)
        (st_q == FUT_ST_REFILL && PREFETCH_FULL) |-> s_refill_done;
    endproperty
    a_handler_next: assert property (p_handler_next) else $error("handler late");

    // Illegal path stacks the short frame two cycles after its first step
    property p_ill_frame;
        @(posedge CLK) disable iff (SYS_RST)
        (st_q == FUT_ST_ILL) |-> ##2 (STATUS_WR && EXC_REQ.format == 4'h0
                                      && EXC_REQ.words == 4'h4);
    endproperty
    a_ill_frame: assert property (p_ill_frame) else $error("bad illegal frame");

    // Conversion end leads to a format-two frame of six words
    property p_unimp_frame;
        @(posedge CLK) disable iff (SYS_RST)
        (st_q == FUT_ST_CONV && FP_CONV_DONE) |-> ##2 (STATUS_WR && EXC_REQ.format == 4'h2
                                                       && EXC_REQ.words == 4'h6);
    endproperty
    a_unimp_frame: assert property (p_unimp_frame) else $error("bad trap frame");
endmodule : fut_trap
